// ===== pkg/bpfs_params.svh
// Contract
// - start ramp only with supply, enable, qualification
// - soft-start level ramps linearly zero to full
// - over-current protection live during ramp
// - soft-start pulled low: high off, low on
// - resume only via fresh ramp after release
// - enable low tristates both gate outputs
// - switching period programmable within frequency range
// - trailing edge: period starts high on
// - lock period to external sync rising edges
// - over-current when sense below ground, low on
// - over-current latches fault, enters hiccup
// - hiccup holds level zero, counts cycles
// - hiccup repeats while overload persists
// - blank over-current sense after low turn-on
// - over-temperature: gates off, level discharged
// - restart via soft-start after cooling hysteresis
// - regulation indicator high at threshold fraction
// - over-voltage: high off, low on meanwhile
// - over-voltage latch until supply/enable cycled
// - minimum on-time; shorter pulses skipped
// - tracking input until handover, then internal
`ifndef BPFS_PARAMS_SVH
`define BPFS_PARAMS_SVH
// -----------------------------------------------------------------
// clock and timing
// -----------------------------------------------------------------
`define BPFS_CLK_MHZ 20
`define BPFS_FSW_MIN_KHZ 250
`define BPFS_FSW_MAX_KHZ 1500
`define BPFS_PERIOD_MAX ((`BPFS_CLK_MHZ * 1000) / `BPFS_FSW_MIN_KHZ)
`define BPFS_PERIOD_MIN ((`BPFS_CLK_MHZ * 1000 + `BPFS_FSW_MAX_KHZ - 1) / `BPFS_FSW_MAX_KHZ)
`define BPFS_BLANK_NS 160
`define BPFS_BLANK_CYC ((`BPFS_BLANK_NS * `BPFS_CLK_MHZ + 999) / 1000)
`define BPFS_MINON_NS 50
`define BPFS_MINON_CYC ((`BPFS_MINON_NS * `BPFS_CLK_MHZ + 999) / 1000)
`define BPFS_DEAD_NS 50
`define BPFS_DEAD_CYC ((`BPFS_DEAD_NS * `BPFS_CLK_MHZ + 999) / 1000)
`define BPFS_HICCUP_CYCLES 4096
`define BPFS_SS_STEP_CYCLES 16
// -----------------------------------------------------------------
// register map
// -----------------------------------------------------------------
`define BPFS_ADDR_CTRL 4'h0
`define BPFS_ADDR_DUTY 4'h4
`define BPFS_ADDR_STATUS 4'h8
`define BPFS_ADDR_SSLVL 4'hC
`define BPFS_CTRL_RST 12'h028
`define BPFS_DUTY_RST 12'h000
`define BPFS_STAT_STATE_LSB 0
`define BPFS_STAT_OCF 8
`define BPFS_STAT_OVF 9
`define BPFS_STAT_REG 10
`define BPFS_STAT_REFINT 11
`define BPFS_STAT_OT 12
`endif

// ===== pkg/bpfs_pkg.sv
package bpfs_pkg;
  // -----------------------------------------------------------------
  // sequencer states, one-hot
  // -----------------------------------------------------------------
  typedef enum logic [7:0] {
    ST_OFF     = 8'h01,
    ST_SSRAMP  = 8'h02,
    ST_RUN     = 8'h04,
    ST_HICCUP  = 8'h08,
    ST_SSSHUT  = 8'h10,
    ST_THERMAL = 8'h20,
    ST_OVDIS   = 8'h40,
    ST_OVLATCH = 8'h80
  } bpfs_state_t;

  // comparator results, all active high
  typedef struct packed {
    logic supply_ok;    // supply above undervoltage_lockout
    logic enable_ok;    // enable above undervoltage_lockout
    logic qualified;    // start-up qualification
    logic ss_low;       // soft-start node below shutdown level
    logic sense_neg;    // current sense below ground
    logic temp_trip;    // die above trip point
    logic temp_cool;    // die below trip minus hysteresis
    logic fb_reg;       // feedback_input at regulation fraction
    logic fb_ov;        // feedback_input above over-voltage fraction
    logic track_hi;     // tracking input above handover
    logic sync_clk;     // external synchronisation clock
  } bpfs_cmp_t;
endpackage : bpfs_pkg

// ===== hw/bpfs_top.sv
`timescale 1ns/1ns
`include "bpfs_params.svh"
module bpfs_top #(
  parameter int PW = 12,
  parameter int SSW = 8,
  parameter int HICCUP_CYCLES = `BPFS_HICCUP_CYCLES,
  parameter int SS_STEP = `BPFS_SS_STEP_CYCLES
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // avalon-mm slave
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_address_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // comparator inputs
  input wire bpfs_pkg::bpfs_cmp_t cmp_i,
  // gate drivers
  output logic high_gate_o,
  output logic high_gate_oe_o,
  output logic low_gate_o,
  output logic low_gate_oe_o,
  // indicators
  output logic regulation_indicator_o,
  output logic ref_internal_o,
  output logic overcurrent_fault_o,
  output logic overvoltage_fault_o
);
  // -----------------------------------------------------------------
  // constants
  // -----------------------------------------------------------------
  localparam logic [PW-1:0] PMIN = PW'(`BPFS_PERIOD_MIN);
  localparam logic [PW-1:0] PMAX = PW'(`BPFS_PERIOD_MAX);
  localparam logic [PW-1:0] DEAD = PW'(`BPFS_DEAD_CYC);
  localparam logic [PW-1:0] MINON = PW'(`BPFS_MINON_CYC);
  localparam logic [3:0] BLANK = 4'(`BPFS_BLANK_CYC);
  localparam logic [SSW-1:0] SS_FULL = {SSW{1'b1}};
  localparam int HW = $clog2(HICCUP_CYCLES + 1);
  localparam int SW = $clog2(SS_STEP + 1);

  // -----------------------------------------------------------------
  // input synchronisers
  // -----------------------------------------------------------------
  bpfs_pkg::bpfs_cmp_t cmp_meta_r;
  bpfs_pkg::bpfs_cmp_t cmp_r;
  logic sync_prev_r;
  logic sync_edge;
  logic por;

  // two flops on every comparator; first stage read only by second
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cmp_meta_r <= '0;
      cmp_r <= '0;
    end else begin
      cmp_meta_r <= cmp_i;
      cmp_r <= cmp_meta_r;
    end
  end

  // sync edge detector looks only at the settled stage
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      sync_prev_r <= 1'b0;
    end else begin
      sync_prev_r <= cmp_r.sync_clk;
    end
  end
  assign sync_edge = cmp_r.sync_clk & ~sync_prev_r;
  assign por = cmp_r.supply_ok & cmp_r.enable_ok;

  // -----------------------------------------------------------------
  // registers and bus slave
  // -----------------------------------------------------------------
  logic [PW-1:0] period_set_r;
  logic [PW-1:0] duty_r;
  logic ack_r;
  logic req;
  logic take;
  logic [31:0] rdata_nxt;
  bpfs_pkg::bpfs_state_t state_r;
  logic [SSW-1:0] ss_level_r;
  logic overcurrent_fault_r;
  logic regulation_r;

  // one wait cycle per access; read data is loaded in the wait cycle
  assign req = avs_read_i | avs_write_i;
  assign take = req & ack_r;
  assign avs_waitrequest_o = req & ~ack_r;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  // write side: low two byte lanes carry the 12-bit fields
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      period_set_r <= PW'(`BPFS_CTRL_RST);
      duty_r <= PW'(`BPFS_DUTY_RST);
    end else if (take && avs_write_i) begin
      if (avs_address_i == `BPFS_ADDR_CTRL) begin
        if (avs_byteenable_i[0]) period_set_r[7:0] <= avs_writedata_i[7:0];
        if (avs_byteenable_i[1]) period_set_r[11:8] <= avs_writedata_i[11:8];
      end else if (avs_address_i == `BPFS_ADDR_DUTY) begin
        if (avs_byteenable_i[0]) duty_r[7:0] <= avs_writedata_i[7:0];
        if (avs_byteenable_i[1]) duty_r[11:8] <= avs_writedata_i[11:8];
      end
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rdata_nxt = 32'h00000000;
    if (avs_address_i == `BPFS_ADDR_CTRL) begin
      rdata_nxt[PW-1:0] = period_set_r;
    end else if (avs_address_i == `BPFS_ADDR_DUTY) begin
      rdata_nxt[PW-1:0] = duty_r;
    end else if (avs_address_i == `BPFS_ADDR_STATUS) begin
      rdata_nxt[`BPFS_STAT_STATE_LSB +: 8] = state_r;
      rdata_nxt[`BPFS_STAT_OCF] = overcurrent_fault_r;
      rdata_nxt[`BPFS_STAT_OVF] = overvoltage_fault_o;
      rdata_nxt[`BPFS_STAT_REG] = regulation_r;
      rdata_nxt[`BPFS_STAT_REFINT] = ref_internal_o;
      rdata_nxt[`BPFS_STAT_OT] = (state_r == bpfs_pkg::ST_THERMAL);
    end else if (avs_address_i == `BPFS_ADDR_SSLVL) begin
      rdata_nxt[SSW-1:0] = ss_level_r;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      avs_readdata_o <= 32'h00000000;
    end else if (avs_read_i && !ack_r) begin
      avs_readdata_o <= rdata_nxt;
    end
  end

  // -----------------------------------------------------------------
  // switching period
  // -----------------------------------------------------------------
  logic [PW-1:0] period_eff;
  logic [PW-1:0] cnt_r;
  logic wrap;

  // out-of-range settings clamp to the supported frequency span
  always_comb begin
    period_eff = period_set_r;
    if (period_set_r < PMIN) period_eff = PMIN;
    if (period_set_r > PMAX) period_eff = PMAX;
  end
  assign wrap = (cnt_r >= period_eff - PW'(1));

  // sync edge restarts the period; free-run must be slower than sync
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cnt_r <= '0;
    end else if (wrap || sync_edge) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + PW'(1);
    end
  end

  // -----------------------------------------------------------------
  // protection and soft-start sequencer
  // -----------------------------------------------------------------
  logic [3:0] ls_cnt_r;
  logic ocp_hit;
  logic [HW-1:0] hic_cnt_r;
  logic hic_done;
  logic [SW-1:0] step_r;
  logic gate_r_hs;
  logic gate_r_ls;
  logic live;

  assign live = (state_r == bpfs_pkg::ST_SSRAMP) || (state_r == bpfs_pkg::ST_RUN);
  // sensed only after blanking, while low side conducts, ramp included
  assign ocp_hit = live && gate_r_ls && (ls_cnt_r >= BLANK) && cmp_r.sense_neg;
  assign hic_done = wrap && (hic_cnt_r == HW'(HICCUP_CYCLES - 1));

  // fault order: over-voltage, thermal, soft-start pull-down, current
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_r <= bpfs_pkg::ST_OFF;
    end else if (!por) begin
      state_r <= bpfs_pkg::ST_OFF;
    end else begin
      case (state_r)
        bpfs_pkg::ST_OFF: begin
          if (cmp_r.qualified) state_r <= bpfs_pkg::ST_SSRAMP;
        end
        bpfs_pkg::ST_SSRAMP, bpfs_pkg::ST_RUN: begin
          if (cmp_r.fb_ov) state_r <= bpfs_pkg::ST_OVDIS;
          else if (cmp_r.temp_trip) state_r <= bpfs_pkg::ST_THERMAL;
          else if (cmp_r.ss_low) state_r <= bpfs_pkg::ST_SSSHUT;
          else if (ocp_hit) state_r <= bpfs_pkg::ST_HICCUP;
          else if (state_r == bpfs_pkg::ST_SSRAMP && ss_level_r == SS_FULL) begin
            state_r <= bpfs_pkg::ST_RUN;
          end
        end
        bpfs_pkg::ST_HICCUP: begin
          if (cmp_r.fb_ov) state_r <= bpfs_pkg::ST_OVDIS;
          else if (cmp_r.temp_trip) state_r <= bpfs_pkg::ST_THERMAL;
          else if (hic_done) state_r <= bpfs_pkg::ST_SSRAMP;
        end
        bpfs_pkg::ST_SSSHUT: begin
          if (cmp_r.fb_ov) state_r <= bpfs_pkg::ST_OVDIS;
          else if (cmp_r.temp_trip) state_r <= bpfs_pkg::ST_THERMAL;
          else if (!cmp_r.ss_low) state_r <= bpfs_pkg::ST_SSRAMP;
        end
        bpfs_pkg::ST_THERMAL: begin
          if (cmp_r.temp_cool && !cmp_r.temp_trip) state_r <= bpfs_pkg::ST_SSRAMP;
        end
        bpfs_pkg::ST_OVDIS: begin
          if (!cmp_r.fb_ov) state_r <= bpfs_pkg::ST_OVLATCH;
        end
        bpfs_pkg::ST_OVLATCH: begin
          state_r <= bpfs_pkg::ST_OVLATCH;
        end
        default: begin
          state_r <= bpfs_pkg::ST_OFF;
        end
      endcase
    end
  end

  // over-current latch: set in live states, cleared at hiccup end
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || !por) begin
      overcurrent_fault_r <= 1'b0;
    end else if (ocp_hit) begin
      overcurrent_fault_r <= 1'b1;
    end else if (state_r == bpfs_pkg::ST_HICCUP && hic_done) begin
      overcurrent_fault_r <= 1'b0;
    end
  end

  // hiccup counts whole switching periods
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || state_r != bpfs_pkg::ST_HICCUP) begin
      hic_cnt_r <= '0;
    end else if (wrap) begin
      hic_cnt_r <= hic_cnt_r + HW'(1);
    end
  end

  // ramp level: zero outside ramp and run, so any fault discharges it
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || !live) begin
      ss_level_r <= '0;
      step_r <= '0;
    end else if (state_r == bpfs_pkg::ST_RUN) begin
      ss_level_r <= SS_FULL;
      step_r <= '0;
    end else if (step_r == SW'(SS_STEP - 1)) begin
      step_r <= '0;
      if (ss_level_r != SS_FULL) ss_level_r <= ss_level_r + SSW'(1);
    end else begin
      step_r <= step_r + SW'(1);
    end
  end

  // -----------------------------------------------------------------
  // trailing-edge modulator and gate outputs
  // -----------------------------------------------------------------
  logic [PW+SSW-1:0] prod;
  logic [PW-1:0] on_dem;
  logic [PW-1:0] on_len;
  logic [PW-1:0] on_max;
  logic hs_want;
  logic ls_want;
  logic oe_nxt;

  // ramp scales the demanded on-time, so the target rises gradually
  assign prod = duty_r * ss_level_r;
  assign on_max = period_eff - DEAD - DEAD - PW'(1);
  always_comb begin
    on_dem = (state_r == bpfs_pkg::ST_RUN) ? duty_r : prod[PW+SSW-1:SSW];
    on_len = (on_dem > on_max) ? on_max : on_dem;
    if (on_len < MINON) on_len = '0;
  end

  always_comb begin
    hs_want = 1'b0;
    ls_want = 1'b0;
    oe_nxt = 1'b1;
    case (state_r)
      bpfs_pkg::ST_SSRAMP, bpfs_pkg::ST_RUN: begin
        // high turns on one dead time after period start; duty count ends it
        hs_want = (on_len != '0) && (cnt_r >= DEAD) && (cnt_r < DEAD + on_len);
        ls_want = (cnt_r >= DEAD + DEAD + on_len);
      end
      bpfs_pkg::ST_SSSHUT, bpfs_pkg::ST_OVDIS: begin
        ls_want = 1'b1;
      end
      bpfs_pkg::ST_OFF: begin
        oe_nxt = 1'b0;
      end
      default: begin
        oe_nxt = 1'b1;
      end
    endcase
  end

  // each side waits for the other's flop to be low: one-cycle dead time
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      gate_r_hs <= 1'b0;
      gate_r_ls <= 1'b0;
      high_gate_oe_o <= 1'b0;
      low_gate_oe_o <= 1'b0;
    end else begin
      gate_r_hs <= hs_want & ~gate_r_ls & ~ls_want;
      gate_r_ls <= ls_want & ~gate_r_hs;
      high_gate_oe_o <= oe_nxt;
      low_gate_oe_o <= oe_nxt;
    end
  end
  assign high_gate_o = gate_r_hs;
  assign low_gate_o = gate_r_ls;

  // blanking counter restarts on every low-side turn-on
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || !gate_r_ls) begin
      ls_cnt_r <= '0;
    end else if (ls_cnt_r < BLANK) begin
      ls_cnt_r <= ls_cnt_r + 4'h1;
    end
  end

  // -----------------------------------------------------------------
  // indicators
  // -----------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      regulation_r <= 1'b0;
      ref_internal_o <= 1'b0;
    end else begin
      regulation_r <= live && cmp_r.fb_reg && !cmp_r.fb_ov;
      ref_internal_o <= cmp_r.track_hi;
    end
  end
  assign regulation_indicator_o = regulation_r;
  assign overcurrent_fault_o = overcurrent_fault_r;
  assign overvoltage_fault_o = (state_r == bpfs_pkg::ST_OVDIS) ||
                               (state_r == bpfs_pkg::ST_OVLATCH);

  // -----------------------------------------------------------------
  // assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  sequence ls_rise_s;
    !gate_r_ls ##1 gate_r_ls;
  endsequence
  sequence ov_hold_s;
    state_r == bpfs_pkg::ST_OVLATCH ##1 state_r == bpfs_pkg::ST_OVLATCH;
  endsequence

  AST_NO_OVERLAP: assert property (!(gate_r_hs && gate_r_ls))
    else $error("both gates on");
  AST_DEAD: assert property (gate_r_hs ##1 !gate_r_hs |-> !gate_r_ls)
    else $error("no dead cycle after high off");
  AST_TRISTATE: assert property (!por |-> ##2 !high_gate_oe_o && !low_gate_oe_o)
    else $error("gates not released while disabled");
  AST_START: assert property (state_r == bpfs_pkg::ST_OFF ##1 state_r == bpfs_pkg::ST_SSRAMP
    |-> $past(cmp_r.qualified) && $past(por))
    else $error("ramp started without qualification");
  AST_RAMP_UP: assert property (state_r == bpfs_pkg::ST_SSRAMP ##1 state_r == bpfs_pkg::ST_SSRAMP
    |-> ss_level_r >= $past(ss_level_r))
    else $error("ramp level fell");
  AST_BLANK: assert property (ls_rise_s |-> !ocp_hit [*4])
    else $error("current sensed inside blanking");
  // the level register clears one edge after the state leaves ramp or run
  AST_HICCUP: assert property (por && ocp_hit && !cmp_r.fb_ov && !cmp_r.temp_trip
    && !cmp_r.ss_low |=> state_r == bpfs_pkg::ST_HICCUP && overcurrent_fault_r
    ##1 ss_level_r == '0)
    else $error("over-current did not enter hiccup");
  AST_SSSHUT: assert property ((state_r == bpfs_pkg::ST_SSSHUT) [*3]
    |-> gate_r_ls && !gate_r_hs)
    else $error("soft-start shutdown not pulling low");
  AST_OV_LATCH: assert property (ov_hold_s |-> !gate_r_hs && !gate_r_ls)
    else $error("gate on while over-voltage latched");
  AST_THERMAL: assert property (por && live && cmp_r.temp_trip && !cmp_r.fb_ov
    |=> state_r == bpfs_pkg::ST_THERMAL ##1 (!gate_r_hs && !gate_r_ls && ss_level_r == '0))
    else $error("thermal trip not handled");
  AST_REG_IND: assert property (regulation_indicator_o |-> $past(cmp_r.fb_reg))
    else $error("indicator high below threshold");
endmodule : bpfs_top

// ===== tb/bpfs_power_stage.sv
`timescale 1ns/1ns
module bpfs_power_stage (
  // clock
  input wire logic ref_clk_i,
  // gate drives from the controller
  input wire logic high_gate_i,
  input wire logic low_gate_i,
  input wire logic high_oe_i,
  input wire logic low_oe_i,
  // overload commanded by the bench
  input wire logic overload_i,
  // sensing results
  output logic sense_neg_o,
  output logic fb_reg_o
);
  // -----------------------------------------------------------------
  // switch node and output network
  // -----------------------------------------------------------------
  logic [7:0] vout_r;

  // sense node dips below ground only while the low fet carries an overload
  assign sense_neg_o = overload_i & low_gate_i & low_oe_i;

  // crude output: each high-side cycle adds charge; no decay, so it cannot
  // model load steps, only the climb towards regulation
  always_ff @(posedge ref_clk_i) begin
    if (!high_oe_i) begin
      vout_r <= 8'h00;
    end else if (high_gate_i && vout_r != 8'hFF) begin
      vout_r <= vout_r + 8'h01;
    end
  end

  // regulation fraction of full scale
  assign fb_reg_o = (vout_r >= 8'hE1);
endmodule : bpfs_power_stage

// ===== tb/bpfs_top_bench.sv
`timescale 1ns/1ns
module bpfs_top_bench;
  // -----------------------------------------------------------------
  // signals
  // -----------------------------------------------------------------
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic ovl = 1'b0;
  logic sy = 1'b0;
  logic sync_on = 1'b0;
  int scnt = 0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic [31:0] q;
  logic [31:0] q2;
  logic wreq, hg, lg, hoe, loe, sn, fr, ocd;
  bpfs_pkg::bpfs_cmp_t c = 11'h010;
  bpfs_pkg::bpfs_cmp_t ci;
  int fail_count = 0;
  int num_checks = 0;
  int oc_rises = 0;
  int hi, per, n;
  typedef struct {logic w; logic [3:0] a; logic [31:0] d; logic [31:0] e;} bpfs_rrow_t;
  typedef struct {logic [31:0] p; logic [31:0] d; int hi; int per;} bpfs_prow_t;
  bpfs_rrow_t rr[8] = '{'{1'b0, 4'h0, 32'h0, 32'h28}, '{1'b0, 4'h4, 32'h0, 32'h0},
    '{1'b0, 4'h8, 32'h0, 32'h1}, '{1'b0, 4'hC, 32'h0, 32'h0},
    '{1'b1, 4'h0, 32'h14, 32'h14}, '{1'b1, 4'h4, 32'hFFFFF00A, 32'hA},
    '{1'b1, 4'h8, 32'hFF, 32'h1}, '{1'b1, 4'h2, 32'h55, 32'h0}};
  bpfs_prow_t pr[5] = '{'{32'h14, 32'hA, 10, 20}, '{32'hE, 32'h1, 1, 14},
    '{32'hE, 32'h14, 11, 14}, '{32'h50, 32'h28, 40, 80}, '{32'hA, 32'h5, 5, 14}};

  always_comb begin
    ci = c;
    ci.sense_neg = sn;
    ci.fb_reg = fr;
    ci.sync_clk = sy;
  end

  // external sync every 40 cycles; the free-run period is set to 50 cycles, 25% longer
  always @(posedge ref_clk_i) begin
    if (sync_on) begin
      scnt <= (scnt == 19) ? 0 : scnt + 1;
      if (scnt == 19) sy <= ~sy;
    end
  end

  bpfs_top #(.HICCUP_CYCLES(4), .SS_STEP(1)) u_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .avs_read_i(rd), .avs_write_i(wr), .avs_address_i(adr), .avs_writedata_i(wd),
    .avs_byteenable_i(4'hF), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .cmp_i(ci),
    .high_gate_o(hg), .high_gate_oe_o(hoe), .low_gate_o(lg), .low_gate_oe_o(loe),
    .regulation_indicator_o(), .ref_internal_o(), .overcurrent_fault_o(),
    .overvoltage_fault_o());

  bpfs_power_stage u_stage (.ref_clk_i(ref_clk_i), .high_gate_i(hg), .low_gate_i(lg),
    .high_oe_i(hoe), .low_oe_i(loe), .overload_i(ovl), .sense_neg_o(sn), .fb_reg_o(fr));

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  initial begin
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  task results;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  // request held until the edge where waitrequest is seen low
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    int k;
    k = 0;
    @(posedge ref_clk_i);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge ref_clk_i);
      k++;
    end while (wreq !== 1'b0 && k < 20);
    r = rdat;
    if (wreq !== 1'b0) begin
      chk(32'h1, 32'h0, "bus hang");
      results();
    end
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  // poll status until the masked field matches, bounded
  task wst(input logic [31:0] m, input logic [31:0] v, input string s);
    int k;
    k = 0;
    do begin
      bus(1'b0, 4'h8, 32'h0, q);
      k++;
    end while ((q & m) !== v && k < 600);
    chk(q & m, v, s);
    if ((q & m) !== v) results();
  endtask : wst

  // gates as {high, low, high_oe, low_oe}
  task gchk(input logic [3:0] e, input string s);
    repeat (3) @(negedge ref_clk_i);
    chk({28'h0, hg, lg, hoe, loe}, {28'h0, e}, s);
  endtask : gchk

  // one full period measured from a clean rising edge of the high gate
  task meas(output int h, output int p);
    int k;
    k = 0;
    h = 0;
    p = 0;
    while (hg !== 1'b0 && k < 300) begin @(negedge ref_clk_i); k++; end
    while (hg !== 1'b1 && k < 300) begin @(negedge ref_clk_i); k++; end
    while (hg === 1'b1 && k < 300) begin @(negedge ref_clk_i); h++; p++; k++; end
    while (hg !== 1'b1 && k < 300) begin @(negedge ref_clk_i); p++; k++; end
    if (k >= 300) begin chk(32'h1, 32'h0, "no switching"); results(); end
  endtask : meas

  // both gates on at once would short the input rail
  always @(negedge ref_clk_i) begin
    if (hg === 1'b1 && lg === 1'b1) chk(32'h1, 32'h0, "shoot through");
    if (u_dut.overcurrent_fault_o === 1'b1 && ocd === 1'b0) oc_rises++;
    ocd = u_dut.overcurrent_fault_o;
  end

  initial begin
    repeat (100000) @(posedge ref_clk_i);
    chk(32'h1, 32'h0, "run too long");
    results();
  end

  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    gchk(4'h0, "reset gates");
    foreach (rr[i]) begin
      if (rr[i].w) bus(1'b1, rr[i].a, rr[i].d, q);
      bus(1'b0, rr[i].a, 32'h0, q);
      chk(q, rr[i].e, "register");
    end
    $display("test registers done");
    c.supply_ok <= 1'b1;
    c.enable_ok <= 1'b1;
    repeat (10) @(posedge ref_clk_i);
    bus(1'b0, 4'h8, 32'h0, q);
    chk(q & 32'hFF, 32'h1, "start unqualified");
    bus(1'b1, 4'h4, 32'hA, q);
    c.qualified <= 1'b1;
    wst(32'hFF, 32'h2, "ramp");
    bus(1'b0, 4'hC, 32'h0, q);
    bus(1'b0, 4'hC, 32'h0, q2);
    chk({31'h0, q2[7:0] > q[7:0]}, 32'h1, "ramp rises");
    wst(32'hFF, 32'h4, "run");
    wst(32'h400, 32'h400, "regulation");
    chk({31'h0, u_dut.regulation_indicator_o}, 32'h1, "indicator");
    @(posedge ref_clk_i);
    c.track_hi <= 1'b1;
    repeat (4) @(negedge ref_clk_i);
    chk({30'h0, hoe, loe}, 32'h3, "drivers on");
    chk({31'h0, u_dut.ref_internal_o}, 32'h1, "internal ref");
    $display("test start done");
    foreach (pr[i]) begin
      bus(1'b1, 4'h0, pr[i].p, q);
      bus(1'b1, 4'h4, pr[i].d, q);
      meas(hi, per);
      meas(hi, per);
      chk(hi, pr[i].hi, "on time");
      chk(per, pr[i].per, "period");
    end
    bus(1'b1, 4'h0, 32'h32, q);
    bus(1'b1, 4'h4, 32'hA, q);
    sync_on <= 1'b1;
    meas(hi, per);
    meas(hi, per);
    chk(per, 40, "sync period");
    sync_on <= 1'b0;
    $display("test periods done");
    bus(1'b1, 4'h0, 32'hE, q);
    bus(1'b1, 4'h4, 32'hB, q);
    ovl <= 1'b1;
    repeat (60) @(negedge ref_clk_i);
    bus(1'b0, 4'h8, 32'h0, q);
    chk(q & 32'h100, 32'h0, "blanked");
    bus(1'b1, 4'h4, 32'h4, q);
    wst(32'h100, 32'h100, "oc latched");
    wst(32'hFF, 32'h8, "hiccup");
    gchk(4'h3, "hiccup gates");
    bus(1'b0, 4'hC, 32'h0, q);
    chk(q, 32'h0, "hiccup level");
    n = 0;
    while (oc_rises < 2 && n < 3000) begin @(negedge ref_clk_i); n++; end
    chk({31'h0, oc_rises >= 2}, 32'h1, "hiccup repeats");
    @(posedge ref_clk_i);
    ovl <= 1'b0;
    wst(32'h1FF, 32'h4, "recovered");
    $display("test overcurrent done");
    c.ss_low <= 1'b1;
    wst(32'hFF, 32'h10, "ss shutdown");
    gchk(4'h7, "ss gates");
    @(posedge ref_clk_i);
    c.ss_low <= 1'b0;
    wst(32'hFF, 32'h2, "ss resume");
    wst(32'hFF, 32'h4, "ss run");
    c.temp_trip <= 1'b1;
    c.temp_cool <= 1'b0;
    wst(32'hFF, 32'h20, "thermal");
    gchk(4'h3, "thermal gates");
    bus(1'b0, 4'hC, 32'h0, q);
    chk(q, 32'h0, "thermal level");
    c.temp_trip <= 1'b0;
    repeat (20) @(posedge ref_clk_i);
    bus(1'b0, 4'h8, 32'h0, q);
    chk(q & 32'hFF, 32'h20, "hysteresis");
    c.temp_cool <= 1'b1;
    wst(32'hFF, 32'h2, "thermal restart");
    $display("test shutdown done");
    c.fb_ov <= 1'b1;
    wst(32'hFF, 32'h40, "ov discharge");
    gchk(4'h7, "ov gates");
    chk({31'h0, u_dut.overvoltage_fault_o}, 32'h1, "ov flag");
    @(posedge ref_clk_i);
    c.fb_ov <= 1'b0;
    wst(32'hFF, 32'h80, "ov latch");
    gchk(4'h3, "ov latched gates");
    @(posedge ref_clk_i);
    c.enable_ok <= 1'b0;
    wst(32'hFF, 32'h1, "enable off");
    gchk(4'h0, "tristate");
    @(posedge ref_clk_i);
    c.enable_ok <= 1'b1;
    wst(32'hFF, 32'h2, "restart");
    $display("test overvoltage done");
    results();
  end
endmodule : bpfs_top_bench
